// ==== design/sdram_timing_defines.vh ====
// Constants for the SDRAM device-side command and data timing logic.
// Assumes a single 250 MHz clock; the memory commands arrive as decoded pins.
`ifndef SDRAM_TIMING_DEFINES_VH
`define SDRAM_TIMING_DEFINES_VH

// ----------------------------------------------------------------------------
// Clock and latencies
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS          4
`define COLUMN_LATENCY         3
`define ACT_TO_COLUMN_CYC      3
`define ACTIVATE_TO_DATA_LATENCY (`ACT_TO_COLUMN_CYC + `COLUMN_LATENCY)
`define STOP_TO_OUTPUT_HIZ     3
`define STOP_TO_INPUT_IGNORE_WRITE 0
`define PRE_TO_OUTPUT_HIZ      3
`define PRE_TO_INPUT_IGNORE    0
`define LAST_OUTPUT_TO_AUTOPRECHARGE 2
`define MASK_TO_OUTPUT_DELAY   2
`define MASK_TO_INPUT_DELAY    0
`define COLUMN_TO_COLUMN_GAP   1

// ----------------------------------------------------------------------------
// Command encodings {ras_n, cas_n, we_n}
// ----------------------------------------------------------------------------
`define CMD_LOAD_MODE          3'b000
`define CMD_REFRESH            3'b001
`define CMD_PRECHARGE          3'b010
`define CMD_ACTIVATE           3'b011
`define CMD_WRITE              3'b100
`define CMD_READ               3'b101
`define CMD_BURST_STOP         3'b110
`define CMD_NOP                3'b111

// ----------------------------------------------------------------------------
// Address fields and reset values
// ----------------------------------------------------------------------------
`define BANK_SELECT_BIT        11
`define AUTO_PRECHARGE_BIT     10
`define ROW_MSB                10
`define COL_MSB                7
`define MODE_RESET             12'h0000
`define BURST_LEN_DEFAULT      4

`endif

// ==== design/sdram_command_timing.v ====
// Device-side SDRAM command decode, bank state and data-path timing.
// Assumes commands and data are synchronous to sys_clk and the controller
// keeps its own spacing rules; storage is a small array standing for the cells.
`timescale 1ns/1ns
`include "sdram_timing_defines.vh"

// What this block does
// - First read word appears six cycles after the row activation.
// - Column commands may arrive every cycle; each is accepted.
// - Burst stop during read floats outputs three cycles later.
// - Burst stop during write ignores input data from that cycle.
// - Precharge during read floats outputs three cycles later.
// - Precharge during write ignores input data from that cycle.
// - Read auto-precharge starts two cycles before the last word.
// - Read byte mask disables the output byte two cycles later.
// - Write byte mask blocks the input byte in the same cycle.
// - Mode load with both banks idle captures all twelve address bits into the mode register.
// - Activate selects bank by bank-select bit, row by bits 0 to 10.
// - Precharge with auto-precharge bit closes both banks, else one.
// - Read with auto-precharge bit closes its bank when the last column of the burst is fetched.
module sdram_command_timing #(
    parameter DATA_W    = 16,
    parameter ADDR_W    = 12,
    parameter COL_W     = 8,
    parameter BURST_LEN = `BURST_LEN_DEFAULT
) (
    // Clock and reset
    input  wire              sys_clk,
    input  wire              rst,
    // Command pins
    input  wire              clk_enable,
    input  wire              chip_select_n,
    input  wire              row_strobe_n,
    input  wire              col_strobe_n,
    input  wire              write_enable_n,
    input  wire [ADDR_W-1:0] addr,
    input  wire              lower_byte_mask,
    input  wire              upper_byte_mask,
    // Data pins
    input  wire [DATA_W-1:0] dq_in,
    output reg  [DATA_W-1:0] dq_out,
    output reg  [1:0]        dq_oe,
    // Status
    output reg  [ADDR_W-1:0] mode_reg,
    output reg  [1:0]        bank_active,
    output reg  [1:0]        auto_precharge_start
);

    localparam RD_PIPE = `COLUMN_LATENCY;
    localparam CNT_W   = 4;

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    wire [2:0] cmd    = {row_strobe_n, col_strobe_n, write_enable_n};
    wire       valid  = clk_enable && !chip_select_n;
    wire       bank   = addr[`BANK_SELECT_BIT];
    wire       ap_bit = addr[`AUTO_PRECHARGE_BIT];
    wire       is_act = valid && cmd == `CMD_ACTIVATE;
    wire       is_pre = valid && cmd == `CMD_PRECHARGE;
    wire       is_rd  = valid && cmd == `CMD_READ;
    wire       is_wr  = valid && cmd == `CMD_WRITE;
    wire       is_bst = valid && cmd == `CMD_BURST_STOP;
    wire       is_mrs = valid && cmd == `CMD_LOAD_MODE;

    // ------------------------------------------------------------------------
    // Storage: one word per bank and column of the open row.
    // ------------------------------------------------------------------------
    reg [DATA_W-1:0]  mem [0:(2<<COL_W)-1];
    reg [`ROW_MSB:0]  open_row_reg [0:1];

    // Burst state
    reg               rd_busy_reg;
    reg               wr_busy_reg;
    reg               burst_bank_reg;
    reg               burst_ap_reg;
    reg [COL_W-1:0]   burst_col_reg;
    reg [CNT_W-1:0]   burst_left_reg;

    // Read pipeline of COLUMN_LATENCY stages: data and valid.
    reg [DATA_W-1:0]  rd_data_pipe [0:RD_PIPE-1];
    reg [RD_PIPE-1:0] rd_valid_pipe;
    // One mask stage plus the output register gives the two-cycle mask delay.
    reg [1:0]         mask_pipe [0:`MASK_TO_OUTPUT_DELAY-2];

    wire [CNT_W-1:0] burst_len_w = BURST_LEN[CNT_W-1:0];
    wire [COL_W:0]   rd_index    = {burst_bank_reg, burst_col_reg};
    wire [COL_W:0]   wr_index_new = {bank, addr[COL_W-1:0]};
    // A new column command, a burst stop or a precharge ends the running burst.
    wire             burst_cut   = is_rd || is_wr || is_bst || is_pre;

    integer i;

    // ------------------------------------------------------------------------
    // Bank and mode state
    // ------------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            bank_active          <= 2'b00;
            mode_reg             <= `MODE_RESET;
            auto_precharge_start <= 2'b00;
            open_row_reg[0]      <= 11'h000;
            open_row_reg[1]      <= 11'h000;
        end else begin
            auto_precharge_start <= 2'b00;
            if (is_act) begin
                bank_active[bank]  <= 1'b1;
                open_row_reg[bank] <= addr[`ROW_MSB:0];
            end
            if (is_pre) begin
                if (ap_bit)
                    bank_active <= 2'b00;
                else
                    bank_active[bank] <= 1'b0;
            end
            if (is_mrs && bank_active == 2'b00)
                mode_reg <= addr;
            // Precharge begins two cycles before the last word leaves the pins,
            // which is when the final column of the burst is fetched.
            if (rd_busy_reg && burst_ap_reg && burst_left_reg == 4'h1 && !burst_cut) begin
                bank_active[burst_bank_reg]          <= 1'b0;
                auto_precharge_start[burst_bank_reg] <= 1'b1;
            end
            if (wr_busy_reg && burst_ap_reg && burst_left_reg == 4'h1 && !burst_cut)
                bank_active[burst_bank_reg] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Burst sequencing; each cycle may bring a fresh column address.
    // ------------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            rd_busy_reg    <= 1'b0;
            wr_busy_reg    <= 1'b0;
            burst_bank_reg <= 1'b0;
            burst_ap_reg   <= 1'b0;
            burst_col_reg  <= 8'h00;
            burst_left_reg <= 4'h0;
        end else if (is_rd || is_wr) begin
            // The command cycle fetches or stores the first column itself.
            rd_busy_reg    <= is_rd && burst_len_w > 4'h1;
            wr_busy_reg    <= is_wr && burst_len_w > 4'h1;
            burst_bank_reg <= bank;
            burst_ap_reg   <= ap_bit;
            burst_col_reg  <= addr[COL_W-1:0] + 8'h01;
            burst_left_reg <= burst_len_w - 4'h1;
        end else if (is_bst || is_pre) begin
            rd_busy_reg <= 1'b0;
            wr_busy_reg <= 1'b0;
        end else if (rd_busy_reg || wr_busy_reg) begin
            burst_col_reg  <= burst_col_reg + 8'h01;
            burst_left_reg <= burst_left_reg - 4'h1;
            if (burst_left_reg == 4'h1) begin
                rd_busy_reg <= 1'b0;
                wr_busy_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Write path: masked bytes are dropped in the cycle they are presented.
    // ------------------------------------------------------------------------
    wire             wr_now   = is_wr || (wr_busy_reg && !is_bst && !is_pre);
    wire [COL_W:0]   wr_index = is_wr ? wr_index_new : rd_index;
    always @(posedge sys_clk) begin
        if (wr_now) begin
            if (!lower_byte_mask)
                mem[wr_index][7:0] <= dq_in[7:0];
            if (!upper_byte_mask)
                mem[wr_index][DATA_W-1:8] <= dq_in[DATA_W-1:8];
        end
    end

    // ------------------------------------------------------------------------
    // Read path: fetch, then latency stages, then the pins.
    // ------------------------------------------------------------------------
    wire             rd_fetch = rd_busy_reg || is_rd;
    wire [COL_W:0]   rd_addr  = is_rd ? wr_index_new : rd_index;
    // Stop and precharge clear the fetch stage's valid bit, so the last
    // word already in flight still leaves and the pins float three cycles on.
    always @(posedge sys_clk) begin
        if (rst) begin
            rd_valid_pipe <= 3'b000;
            dq_out        <= 16'h0000;
            dq_oe         <= 2'b00;
            for (i = 0; i < RD_PIPE; i = i + 1)
                rd_data_pipe[i] <= 16'h0000;
            for (i = 0; i < `MASK_TO_OUTPUT_DELAY - 1; i = i + 1)
                mask_pipe[i] <= 2'b00;
        end else begin
            rd_data_pipe[0]  <= mem[rd_addr];
            rd_valid_pipe[0] <= rd_fetch && !is_bst && !is_pre;
            for (i = 1; i < RD_PIPE - 1; i = i + 1) begin
                rd_data_pipe[i]  <= rd_data_pipe[i-1];
                rd_valid_pipe[i] <= rd_valid_pipe[i-1];
            end
            mask_pipe[0] <= {upper_byte_mask, lower_byte_mask};
            for (i = 1; i < `MASK_TO_OUTPUT_DELAY - 1; i = i + 1)
                mask_pipe[i] <= mask_pipe[i-1];
            // Activate + 3 gives read, read + 3 gives data: six in all.
            dq_out <= rd_data_pipe[RD_PIPE-2];
            dq_oe  <= {2{rd_valid_pipe[RD_PIPE-2]}} & ~mask_pipe[`MASK_TO_OUTPUT_DELAY-2];
        end
    end

endmodule

// ==== dv/sdram_command_timing_monitor.sv ====
// Checker for the device-side SDRAM timing block, bound to its ports.
// Assumes the command codes and address bit positions of the shared defines header.
`timescale 1ns/1ns
`include "sdram_timing_defines.vh"
module sdram_command_timing_monitor #(
    parameter ADDR_W = 12
) (
    // Watched ports
    input wire              sys_clk,
    input wire              rst,
    input wire              clk_enable,
    input wire              chip_select_n,
    input wire              row_strobe_n,
    input wire              col_strobe_n,
    input wire              write_enable_n,
    input wire [ADDR_W-1:0] addr,
    input wire              lower_byte_mask,
    input wire              upper_byte_mask,
    input wire [1:0]        dq_oe,
    input wire [ADDR_W-1:0] mode_reg,
    input wire [1:0]        bank_active,
    input wire [1:0]        auto_precharge_start
);
    // A deselected or clock-gated cycle counts as no operation.
    wire [2:0] cmd  = (clk_enable && !chip_select_n) ? {row_strobe_n, col_strobe_n, write_enable_n} : `CMD_NOP;
    wire       calm = cmd == `CMD_NOP && !lower_byte_mask && !upper_byte_mask;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_read; cmd == `CMD_READ && bank_active[addr[`BANK_SELECT_BIT]]; endsequence
    sequence s_read_ap; cmd == `CMD_READ && addr[`AUTO_PRECHARGE_BIT] && !addr[`BANK_SELECT_BIT]; endsequence
    property p_reset_clear; disable iff (1'b0) rst |=> dq_oe == 2'b00 && bank_active == 2'b00
        && mode_reg == 12'h000 && auto_precharge_start == 2'b00; endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
    property p_read_latency; s_read ##1 calm[*2] |=> dq_oe == 2'b11; endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data late");
    property p_read_ap; s_read_ap ##1 (cmd == `CMD_NOP)[*3] |=> auto_precharge_start[0] && !bank_active[0]; endproperty
    a_read_ap: assert property (p_read_ap) else $error("auto precharge start wrong");
    property p_read_cut; cmd == `CMD_BURST_STOP || (cmd == `CMD_PRECHARGE && addr[10]) |-> ##3 dq_oe == 2'b00; endproperty
    a_read_cut: assert property (p_read_cut) else $error("outputs still driven after cut");
    property p_mask_read; lower_byte_mask |-> ##2 !dq_oe[0]; endproperty
    a_mask_read: assert property (p_mask_read) else $error("masked byte driven");
    property p_activate; cmd == `CMD_ACTIVATE && addr[`BANK_SELECT_BIT] |=> bank_active[1]; endproperty
    a_activate: assert property (p_activate) else $error("bank not opened");
    property p_precharge_all; cmd == `CMD_PRECHARGE && addr[10] |=> bank_active == 2'b00; endproperty
    a_precharge_all: assert property (p_precharge_all) else $error("banks not closed");
    property p_mode_load; cmd == `CMD_LOAD_MODE && bank_active == 2'b00 |=> mode_reg == $past(addr); endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode value not captured");
endmodule
bind sdram_command_timing sdram_command_timing_monitor #(.ADDR_W(ADDR_W)) sdram_command_timing_monitor_i (
    .sys_clk, .rst, .clk_enable, .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n, .addr,
    .lower_byte_mask, .upper_byte_mask, .dq_oe, .mode_reg, .bank_active, .auto_precharge_start);

// ==== dv/sdram_ctrl_model.sv ====
// Controller-side model driving the SDRAM command, mask and write-data pins.
// Assumes the bench orders the commands and inserts the spacing gaps.
`timescale 1ns/1ns
`include "sdram_timing_defines.vh"
module sdram_ctrl_model (
    // Clock
    input  wire        sys_clk,
    // Pins toward the device
    output reg         clk_enable,
    output reg         chip_select_n,
    output reg         row_strobe_n,
    output reg         col_strobe_n,
    output reg         write_enable_n,
    output reg  [11:0] addr,
    output reg         lower_byte_mask,
    output reg         upper_byte_mask,
    output reg  [15:0] dq_in
);
    // Clock enable stays high from the start, so no recovery gap is ever owed.
    initial {clk_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n, addr, upper_byte_mask,
        lower_byte_mask, dq_in} = {2'b10, `CMD_NOP, 12'h000, 2'b00, 16'h0000};
    task issue(input [2:0] c, input [11:0] a, input [15:0] d, input [1:0] m);
        @(posedge sys_clk);
        #1;
        {row_strobe_n, col_strobe_n, write_enable_n} = c;
        addr = a;
        dq_in = d;
        {upper_byte_mask, lower_byte_mask} = m;
    endtask
    // Idle lines flip every cycle, because a held value could pass for valid data.
    task nop(input integer n);
        repeat (n) issue(`CMD_NOP, ~addr, ~dq_in, 2'b00);
    endtask
endmodule

// ==== dv/tb_sdram_command_timing.sv ====
// Self-checking bench for the device-side SDRAM timing block.
// Assumes the controller model drives all command pins; bank 0 columns are mirrored here.
`timescale 1ns/1ns
`include "sdram_timing_defines.vh"
module tb_sdram_command_timing;
    reg         sys_clk = 1'b0;
    reg         rst     = 1'b1;
    wire        clk_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
    wire        lower_byte_mask, upper_byte_mask;
    wire [11:0] addr, mode_reg;
    wire [15:0] dq_in, dq_out;
    wire [1:0]  dq_oe, bank_active, auto_precharge_start;
    integer     err_total = 0, n_compared = 0, cycles = 0, seed = 32'h9a73a9e0, j, k;
    reg  [15:0] mem [0:255];
    reg  [15:0] d;
    reg  [11:0] m;
    reg  [7:0]  c, i;
    always #2 sys_clk = ~sys_clk;
    sdram_ctrl_model sdram_ctrl_model_i (.sys_clk, .clk_enable, .chip_select_n, .row_strobe_n, .col_strobe_n,
        .write_enable_n, .addr, .lower_byte_mask, .upper_byte_mask, .dq_in);
    sdram_command_timing sdram_command_timing_i (.sys_clk, .rst, .clk_enable, .chip_select_n, .row_strobe_n,
        .col_strobe_n, .write_enable_n, .addr, .lower_byte_mask, .upper_byte_mask, .dq_in, .dq_out, .dq_oe,
        .mode_reg, .bank_active, .auto_precharge_start);
    task cmd(input [2:0] cc, input [11:0] a, input [1:0] mm);
        sdram_ctrl_model_i.issue(cc, a, ~dq_in, mm);
    endtask
    task idle(input integer n);
        sdram_ctrl_model_i.nop(n);
    endtask
    task check(input string what, input [15:0] e, input [15:0] s);
        n_compared = n_compared + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task wr(input [7:0] col, input integer stop, input [3:0] lm);
        for (k = 0; k < 4; k = k + 1) begin
            d = $random(seed);
            i = col + k;
            sdram_ctrl_model_i.issue(k == 0 ? `CMD_WRITE : (k == stop ? `CMD_BURST_STOP : `CMD_NOP),
                {4'h0, col}, d, {lm[k], lm[k]});
            if (k < stop && !lm[k]) mem[i] = d;
        end
    endtask
    // Word j of the burst is masked by the mask bit sampled one edge after its fetch.
    task rd(input [7:0] col, input integer n, input [7:0] lm, input pre);
        cmd(`CMD_READ, {4'h0, col}, 2'b00);
        for (k = 1; k <= n + 2; k = k + 1) begin
            cmd(`CMD_NOP, ~addr, {lm[k - 1], lm[k - 1]});
            i = col + k - 3;
            if (pre && k == 2) check("cut word", mem[col - 8'd2], dq_out);
            if (k >= 3) check("oe", {2{~lm[k - 3]}}, dq_oe);
            if (k >= 3 && !lm[k - 3]) check("read word", mem[i], dq_out);
        end
    endtask
    task cut(input [2:0] cc, input [11:0] a);
        idle(4);
        cmd(`CMD_READ, 12'h0fe, 2'b00);
        cmd(cc, a, 2'b00);
        idle(2);
        check("last word", mem[8'hfe], dq_out);
        idle(1);
        check("float", 2'b00, dq_oe);
    endtask
    task conclude;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            err_total = err_total + 1;
            conclude;
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        // Gaps below are the nanosecond minimums rounded up at the 4 ns period.
        idle(25000);
        m = $random(seed);
        cmd(`CMD_LOAD_MODE, m, 2'b00);
        idle(2);
        check("mode", m, mode_reg);
        cmd(`CMD_REFRESH, 12'h000, 2'b00);
        idle(19);
        d = $random(seed);
        cmd(`CMD_ACTIVATE, {1'b0, d[10:0]}, 2'b00);
        idle(3);
        cmd(`CMD_ACTIVATE, {1'b1, d[10:0]}, 2'b00);
        idle(5);
        check("open", 2'b11, bank_active);
        cmd(`CMD_LOAD_MODE, ~m, 2'b00);
        idle(2);
        check("mode kept", m, mode_reg);
        wr(8'hfe, 4, 4'h0);
        wr(8'hfe, 3, 4'b0010);
        rd(8'hfe, 4, 8'h04, 1'b0);
        cmd(`CMD_READ, 12'h0fe, 2'b00);
        rd(8'h00, 2, 8'h00, 1'b1);
        for (j = 0; j < 3; j = j + 1) begin
            c = $random(seed);
            d = $random(seed);
            wr(c, 4, 4'h0);
            rd(c, 4, d[7:0], 1'b0);
        end
        cut(`CMD_BURST_STOP, 12'h000);
        cmd(`CMD_PRECHARGE, 12'h800, 2'b00);
        idle(1);
        check("one closed", 2'b01, bank_active);
        cut(`CMD_PRECHARGE, 12'h400);
        check("all closed", 2'b00, bank_active);
        idle(3);
        cmd(`CMD_ACTIVATE, 12'h000, 2'b00);
        idle(8);
        cmd(`CMD_READ, 12'h4fe, 2'b00);
        idle(4);
        check("ap start", 2'b01, auto_precharge_start);
        check("ap closed", 2'b00, bank_active);
        idle(6);
        cmd(`CMD_ACTIVATE, 12'h000, 2'b00);
        idle(8);
        cmd(`CMD_WRITE, 12'h410, 2'b00);
        idle(3);
        idle(5);
        check("write ap closed", 2'b00, bank_active);
        conclude;
    end
endmodule
